/* hw/i2c_host_pkg.sv */
// Constants shared by the I2C host bus-state and clocking block
package i2c_host_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_BAUD   = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_ADDR   = 8'h0c;
   localparam logic [7:0] OFS_DATA   = 8'h10;
   localparam logic [7:0] OFS_CMD    = 8'h14;

   // ==========================================================
   // Control field positions
   localparam int CTRL_EN_BIT    = 0;
   localparam int CTRL_SOFT_RESET_BIT_BIT = 1;
   localparam int CTRL_CLOCK_STRETCH_MODE_BIT = 2;
   localparam int CTRL_SMART_MODE_ENABLE_BIT  = 3;
   localparam int CTRL_HS_BIT    = 4;
   localparam int CTRL_INACT_LSB = 5;

   // ==========================================================
   // Status field positions
   localparam int ST_BUS_LSB  = 0;
   localparam int ST_ARB_BIT  = 2;
   localparam int ST_BERR_BIT = 3;
   localparam int ST_NACK_BIT = 4;
   localparam int ST_MB_BIT   = 5;
   localparam int ST_BUSY_BIT = 6;

   // ==========================================================
   // Bus state encodings and commands
   localparam logic [1:0] BS_UNKNOWN = 2'h0;
   localparam logic [1:0] BS_IDLE    = 2'h1;
   localparam logic [1:0] BS_OWNER   = 2'h2;
   localparam logic [1:0] BS_BUSY    = 2'h3;
   localparam logic [1:0] CMD_STOP   = 2'h3;

   // ==========================================================
   // Reset values
   localparam logic [31:0] BAUD_RST = 32'h0000_0000;
   localparam logic [7:0]  ADDR_RST = 8'h00;

   // ==========================================================
   // Timing
   localparam logic [9:0] SCL_EXTRA   = 10'h005;
   localparam logic [9:0] HS_EXTRA    = 10'h001;
   localparam logic [9:0] SMART_SETUP = 10'h006;
   localparam int CLK_MHZ   = 250;
   localparam int INACT_US1 = 55;
   localparam int INACT_US2 = 105;
   localparam int INACT_US3 = 205;
   localparam int INACT_CYC1 = INACT_US1 * CLK_MHZ;
   localparam int INACT_CYC2 = INACT_US2 * CLK_MHZ;
   localparam int INACT_CYC3 = INACT_US3 * CLK_MHZ;

endpackage

/* hw/i2c_line_sync.sv */
// Line synchroniser with start and stop detection
`timescale 1ns/1ps
`default_nettype none
module i2c_line_sync (
   input  wire logic sys_clk_in,
   input  wire logic rst_in,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_out,
   output logic      start_out,
   output logic      stop_out
);
   // ==========================================================
   // Two-stage sync plus history stage
   logic [1:0] scl_meta_q;
   logic [1:0] sda_meta_q;
   logic       scl_last_q;
   logic       sda_last_q;

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         scl_meta_q <= 2'h3;
         sda_meta_q <= 2'h3;
         scl_last_q <= 1'b1;
         sda_last_q <= 1'b1;
      end else begin
         scl_meta_q <= {scl_meta_q[0], scl_in};
         sda_meta_q <= {sda_meta_q[0], sda_in};
         scl_last_q <= scl_meta_q[1];
         sda_last_q <= sda_meta_q[1];
      end
   end

   // ==========================================================
   // SDA edges while SCL high
   assign scl_out   = scl_meta_q[1];
   assign sda_out   = sda_meta_q[1];
   assign start_out = scl_meta_q[1] && scl_last_q && sda_last_q
                      && !sda_meta_q[1];
   assign stop_out  = scl_meta_q[1] && scl_last_q && !sda_last_q
                      && sda_meta_q[1];
endmodule
`default_nettype wire

/* hw/i2c_host_bus.sv */
// I2C host bus-state tracking, SCL generation and address phase
`timescale 1ns/1ps
`default_nettype none
module i2c_host_bus #(
   parameter int unsigned INACT_CYC1 = i2c_host_pkg::INACT_CYC1,
   parameter int unsigned INACT_CYC2 = i2c_host_pkg::INACT_CYC2,
   parameter int unsigned INACT_CYC3 = i2c_host_pkg::INACT_CYC3
) (
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   input  wire logic [7:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             scl_out,
   output logic             scl_oe_n_out,
   output logic             sda_out,
   output logic             sda_oe_n_out
);
   import i2c_host_pkg::*;

   typedef enum logic [3:0] {
      E_IDLE, E_START, E_LOW, E_HIGH, E_HOLD, E_RS_LOW, E_RS_HIGH,
      E_STOP_LOW, E_STOP_HIGH, E_FREE
   } eng_t;

   logic        wait_q;
   logic [31:0] rdata_q;
   logic        srst_q;
   logic        en_q;
   logic        clock_stretch_mode_q;
   logic        smart_mode_enable_q;
   logic        hs_q;
   logic [1:0]  inact_sel_q;
   logic [31:0] baud_q;
   logic [7:0]  addr_q;
   logic [7:0]  data_q;
   logic [1:0]  bus_state_q;
   logic        arb_q;
   logic        berr_q;
   logic        nack_q;
   logic        mb_q;
   eng_t        eng_q;
   logic [9:0]  tcnt_q;
   logic [3:0]  bit_cnt_q;
   logic [7:0]  shift_q;
   logic        apend_q;
   logic        dpend_q;
   logic        spend_q;
   logic        scl_oe_n_q;
   logic        sda_oe_n_q;
   logic        zero_q;
   logic [15:0] inact_q;

   logic        scl_s;
   logic        sda_s;
   logic        start_det;
   logic        stop_det;

   // ==========================================================
   // Pin synchroniser and condition detectors
   i2c_line_sync u_sync (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .scl_in     (scl_in),
      .sda_in     (sda_in),
      .scl_out    (scl_s),
      .sda_out    (sda_s),
      .start_out  (start_det),
      .stop_out   (stop_det)
   );

   // ==========================================================
   // Bus decode
   logic take;
   logic wr_take;
   logic wr_ctrl;
   logic wr_baud;
   logic wr_status;
   logic wr_addr;
   logic wr_data;
   logic wr_cmd;

   assign take      = (avs_read_in || avs_write_in) && !wait_q;
   assign wr_take   = avs_write_in && !wait_q;
   assign wr_ctrl   = wr_take && avs_address_in == OFS_CTRL
                      && avs_byteenable_in[0];
   assign wr_baud   = wr_take && avs_address_in == OFS_BAUD && !en_q;
   assign wr_status = wr_take && avs_address_in == OFS_STATUS
                      && avs_byteenable_in[0];
   assign wr_addr   = wr_take && avs_address_in == OFS_ADDR
                      && avs_byteenable_in[0] && en_q;
   assign wr_data   = wr_take && avs_address_in == OFS_DATA
                      && avs_byteenable_in[0] && en_q;
   assign wr_cmd    = wr_take && avs_address_in == OFS_CMD
                      && avs_byteenable_in[0] && en_q
                      && avs_writedata_in[1:0] == CMD_STOP;

   // ==========================================================
   // Phase lengths
   logic [7:0] main_cnt;
   logic [7:0] low_cnt;
   logic [7:0] fmain_cnt;
   logic [7:0] flow_cnt;
   logic [9:0] t_low_c;
   logic [9:0] t_high_c;
   logic [9:0] t_low_ld;
   logic [9:0] t_high_ld;

   assign main_cnt  = baud_q[7:0];
   assign low_cnt   = baud_q[15:8];
   assign fmain_cnt = baud_q[23:16];
   assign flow_cnt  = baud_q[31:24];

   always_comb begin
      if (hs_q) begin
         t_low_c  = ((flow_cnt != 8'h00) ? {2'h0, flow_cnt}
                                         : {2'h0, fmain_cnt}) + HS_EXTRA;
         t_high_c = {2'h0, fmain_cnt} + HS_EXTRA;
      end else begin
         t_low_c  = ((low_cnt != 8'h00) ? {2'h0, low_cnt}
                                        : {2'h0, main_cnt}) + SCL_EXTRA;
         t_high_c = {2'h0, main_cnt} + SCL_EXTRA;
      end
      if (smart_mode_enable_q && t_low_c <= SMART_SETUP) begin
         t_low_c = SMART_SETUP + 10'h001;
      end
   end

   assign t_low_ld  = t_low_c - 10'h001;
   assign t_high_ld = t_high_c - 10'h001;

   // ==========================================================
   // Engine events
   logic hi_run;
   logic t_done;
   logic bit_done;
   logic berr_ev;
   logic arb_ev;
   logic ack_ev;
   logic go_start;
   logic inact_exp;
   logic [15:0] inact_lim;

   assign hi_run   = scl_s || hs_q;
   assign t_done   = tcnt_q == 10'h000;
   assign bit_done = eng_q == E_HIGH && hi_run && t_done;
   assign berr_ev  = (eng_q == E_LOW || eng_q == E_HIGH)
                     && (start_det || stop_det);
   assign arb_ev   = berr_ev
                     || (bit_done && bit_cnt_q != 4'h8 && sda_oe_n_q
                         && !sda_s)
                     || (eng_q == E_RS_HIGH && hi_run && !sda_s);
   assign ack_ev   = bit_done && bit_cnt_q == 4'h8 && !arb_ev;
   assign go_start = en_q && eng_q == E_IDLE && apend_q
                     && bus_state_q == BS_IDLE;

   always_comb begin
      case (inact_sel_q)
         2'h1:    inact_lim = INACT_CYC1[15:0];
         2'h2:    inact_lim = INACT_CYC2[15:0];
         2'h3:    inact_lim = INACT_CYC3[15:0];
         default: inact_lim = 16'hffff;
      endcase
   end
   assign inact_exp = inact_sel_q != 2'h0 && inact_q == inact_lim;

   // ==========================================================
   // Avalon slave handshake
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         wait_q <= !((avs_read_in || avs_write_in) && wait_q);
         if (avs_read_in && wait_q) begin
            case (avs_address_in)
               OFS_CTRL:   rdata_q <= {25'h0, inact_sel_q, hs_q, smart_mode_enable_q,
                                       clock_stretch_mode_q, 1'b0, en_q};
               OFS_BAUD:   rdata_q <= baud_q;
               OFS_STATUS: rdata_q <= {25'h0, eng_q != E_IDLE || apend_q,
                                       mb_q, nack_q, berr_q, arb_q,
                                       bus_state_q};
               OFS_ADDR:   rdata_q <= {24'h0, addr_q};
               OFS_DATA:   rdata_q <= {24'h0, data_q};
               default:    rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ==========================================================
   // Control and baud registers
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         srst_q      <= 1'b0;
         en_q        <= 1'b0;
         clock_stretch_mode_q     <= 1'b0;
         smart_mode_enable_q      <= 1'b0;
         hs_q        <= 1'b0;
         inact_sel_q <= 2'h0;
         baud_q      <= BAUD_RST;
         addr_q      <= ADDR_RST;
         data_q      <= 8'h00;
      end else if (srst_q) begin
         srst_q      <= 1'b0;
         en_q        <= 1'b0;
         clock_stretch_mode_q     <= 1'b0;
         smart_mode_enable_q      <= 1'b0;
         hs_q        <= 1'b0;
         inact_sel_q <= 2'h0;
         baud_q      <= BAUD_RST;
         addr_q      <= ADDR_RST;
         data_q      <= 8'h00;
      end else begin
         srst_q <= wr_ctrl && avs_writedata_in[CTRL_SOFT_RESET_BIT_BIT];
         if (wr_ctrl) begin
            en_q <= avs_writedata_in[CTRL_EN_BIT];
            if (!en_q) begin
               clock_stretch_mode_q     <= avs_writedata_in[CTRL_CLOCK_STRETCH_MODE_BIT];
               smart_mode_enable_q      <= avs_writedata_in[CTRL_SMART_MODE_ENABLE_BIT];
               hs_q        <= avs_writedata_in[CTRL_HS_BIT];
               inact_sel_q <= avs_writedata_in[CTRL_INACT_LSB +: 2];
            end
         end
         for (int i = 0; i < 4; i++) begin
            if (wr_baud && avs_byteenable_in[i]) begin
               baud_q[i*8 +: 8] <= avs_writedata_in[i*8 +: 8];
            end
         end
         if (wr_addr) begin
            addr_q <= avs_writedata_in[7:0];
         end
         if (wr_data) begin
            data_q <= avs_writedata_in[7:0];
         end
      end
   end

   // ==========================================================
   // Inactivity timer
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         inact_q <= 16'h0000;
      end else if (!(scl_s && sda_s) || inact_exp || !en_q) begin
         inact_q <= 16'h0000;
      end else if (inact_sel_q != 2'h0) begin
         inact_q <= inact_q + 16'h0001;
      end
   end

   // ==========================================================
   // Bus state
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         bus_state_q <= BS_UNKNOWN;
      end else if (srst_q || !en_q) begin
         bus_state_q <= BS_UNKNOWN;
      end else begin
         case (bus_state_q)
            BS_UNKNOWN: begin
               if ((wr_status && avs_writedata_in[1:0] == BS_IDLE)
                   || stop_det || inact_exp) begin
                  bus_state_q <= BS_IDLE;
               end
            end
            BS_IDLE: begin
               if (go_start) begin
                  bus_state_q <= BS_OWNER;
               end else if (start_det) begin
                  bus_state_q <= BS_BUSY;
               end
            end
            BS_OWNER: begin
               if (arb_ev) begin
                  bus_state_q <= BS_BUSY;
               end else if (stop_det) begin
                  bus_state_q <= BS_IDLE;
               end
            end
            BS_BUSY: begin
               if (stop_det || inact_exp) begin
                  bus_state_q <= BS_IDLE;
               end
            end
            default: bus_state_q <= BS_UNKNOWN;
         endcase
      end
   end

   // ==========================================================
   // Status flags, set wins over clear
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         arb_q  <= 1'b0;
         berr_q <= 1'b0;
         nack_q <= 1'b0;
         mb_q   <= 1'b0;
      end else if (srst_q || !en_q) begin
         arb_q  <= 1'b0;
         berr_q <= 1'b0;
         nack_q <= 1'b0;
         mb_q   <= 1'b0;
      end else begin
         if (wr_addr) begin
            arb_q  <= 1'b0;
            berr_q <= 1'b0;
            nack_q <= 1'b0;
            mb_q   <= 1'b0;
         end
         if (wr_status && avs_writedata_in[ST_MB_BIT]) begin
            mb_q <= 1'b0;
         end
         if (arb_ev) begin
            arb_q <= 1'b1;
            mb_q  <= 1'b1;
         end
         if (berr_ev) begin
            berr_q <= 1'b1;
         end
         if (ack_ev) begin
            nack_q <= sda_s;
            mb_q   <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Bit engine and pin drivers
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         eng_q      <= E_IDLE;
         tcnt_q     <= 10'h000;
         bit_cnt_q  <= 4'h0;
         shift_q    <= 8'h00;
         apend_q    <= 1'b0;
         dpend_q    <= 1'b0;
         spend_q    <= 1'b0;
         scl_oe_n_q <= 1'b1;
         sda_oe_n_q <= 1'b1;
      end else if (srst_q || !en_q || arb_ev) begin
         eng_q      <= E_IDLE;
         tcnt_q     <= 10'h000;
         apend_q    <= 1'b0;
         dpend_q    <= 1'b0;
         spend_q    <= 1'b0;
         scl_oe_n_q <= 1'b1;
         sda_oe_n_q <= 1'b1;
      end else begin
         if (!t_done && (eng_q != E_HIGH && eng_q != E_RS_HIGH
                         && eng_q != E_STOP_HIGH || hi_run)) begin
            tcnt_q <= tcnt_q - 10'h001;
         end
         case (eng_q)
            E_IDLE: begin
               scl_oe_n_q <= 1'b1;
               sda_oe_n_q <= 1'b1;
               if (go_start) begin
                  sda_oe_n_q <= 1'b0;
                  tcnt_q     <= t_low_ld;
                  shift_q    <= addr_q;
                  apend_q    <= 1'b0;
                  eng_q      <= E_START;
               end
            end
            E_START: begin
               if (t_done) begin
                  scl_oe_n_q <= 1'b0;
                  bit_cnt_q  <= 4'h0;
                  tcnt_q     <= t_low_ld;
                  eng_q      <= E_LOW;
               end
            end
            E_LOW: begin
               sda_oe_n_q <= bit_cnt_q == 4'h8 || shift_q[7];
               if (t_done) begin
                  scl_oe_n_q <= 1'b1;
                  tcnt_q     <= t_high_ld;
                  eng_q      <= E_HIGH;
               end
            end
            E_HIGH: begin
               if (bit_done) begin
                  scl_oe_n_q <= 1'b0;
                  if (bit_cnt_q == 4'h8) begin
                     eng_q <= E_HOLD;
                  end else begin
                     shift_q   <= {shift_q[6:0], 1'b0};
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                     tcnt_q    <= t_low_ld;
                     eng_q     <= E_LOW;
                  end
               end
            end
            E_HOLD: begin
               if (spend_q) begin
                  spend_q    <= 1'b0;
                  sda_oe_n_q <= 1'b0;
                  tcnt_q     <= t_low_ld;
                  eng_q      <= E_STOP_LOW;
               end else if (apend_q) begin
                  apend_q    <= 1'b0;
                  shift_q    <= addr_q;
                  sda_oe_n_q <= 1'b1;
                  tcnt_q     <= t_low_ld;
                  eng_q      <= E_RS_LOW;
               end else if (dpend_q) begin
                  dpend_q   <= 1'b0;
                  shift_q   <= data_q;
                  bit_cnt_q <= 4'h0;
                  tcnt_q    <= t_low_ld;
                  eng_q     <= E_LOW;
               end
            end
            E_RS_LOW: begin
               if (t_done) begin
                  scl_oe_n_q <= 1'b1;
                  tcnt_q     <= t_low_ld;
                  eng_q      <= E_RS_HIGH;
               end
            end
            E_RS_HIGH: begin
               if (t_done && hi_run) begin
                  sda_oe_n_q <= 1'b0;
                  tcnt_q     <= t_low_ld;
                  eng_q      <= E_START;
               end
            end
            E_STOP_LOW: begin
               if (t_done) begin
                  scl_oe_n_q <= 1'b1;
                  tcnt_q     <= t_low_ld;
                  eng_q      <= E_STOP_HIGH;
               end
            end
            E_STOP_HIGH: begin
               if (t_done && hi_run) begin
                  sda_oe_n_q <= 1'b1;
                  tcnt_q     <= t_low_ld;
                  eng_q      <= E_FREE;
               end
            end
            E_FREE: begin
               if (t_done) begin
                  eng_q <= E_IDLE;
               end
            end
            default: eng_q <= E_IDLE;
         endcase
         if (wr_addr) begin
            apend_q <= 1'b1;
         end
         if (wr_data) begin
            dpend_q <= 1'b1;
         end
         if (wr_cmd) begin
            spend_q <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Output flops
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         zero_q <= 1'b0;
      end else begin
         zero_q <= 1'b0;
      end
   end

   assign avs_readdata_out    = rdata_q;
   assign avs_waitrequest_out = wait_q;
   assign scl_out             = zero_q;
   assign sda_out             = zero_q;
   assign scl_oe_n_out        = scl_oe_n_q;
   assign sda_oe_n_out        = sda_oe_n_q;
endmodule
`default_nettype wire

/* test/i2c_host_bus_assertions.sv */
// Port-level checks for the I2C host block
`timescale 1ns/1ps
`default_nettype none
module i2c_host_bus_assertions
   import i2c_host_pkg::*;
(
   input wire logic        sys_clk_in,
   input wire logic        rst_in,
   input wire logic [7:0]  avs_address_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out,
   input wire logic        scl_out,
   input wire logic        scl_oe_n_out,
   input wire logic        sda_out,
   input wire logic        sda_oe_n_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);
   // ==========
   // Bus request and start condition
   sequence req_s;
      (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence start_s;
      $fell(sda_oe_n_out) && scl_oe_n_out;
   endsequence
   a_wait_answer: assert property (req_s |=> !avs_waitrequest_out)
      else $error("no answer");
   a_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("wait low too long");
   a_wait_cause: assert property (!avs_waitrequest_out
      |-> $past(avs_read_in || avs_write_in)) else $error("wait dropped");
   a_rdata_hold: assert property ($changed(avs_readdata_out)
      |-> avs_read_in && !avs_waitrequest_out) else $error("rdata moved");
   a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out
      && avs_address_in > OFS_CMD |-> avs_readdata_out == 32'h0)
      else $error("unmapped read");
   a_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
      else $error("drive level");
   a_low_min: assert property ($fell(scl_oe_n_out)
      |-> !scl_oe_n_out [*2]) else $error("low short");
   a_start_hold: assert property (start_s |-> scl_oe_n_out [*2])
      else $error("start hold short");
endmodule
bind i2c_host_bus i2c_host_bus_assertions chk_u (
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_readdata_out(avs_readdata_out), .scl_out(scl_out),
   .avs_waitrequest_out(avs_waitrequest_out), .sda_out(sda_out),
   .scl_oe_n_out(scl_oe_n_out), .sda_oe_n_out(sda_oe_n_out));
`default_nettype wire

/* test/i2c_bus_partner.sv */
// I2C client and competing-host model
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_partner #(
   parameter logic [6:0] ADDR = 7'h2a
) (
   input  wire logic scl_in,
   input  wire logic sda_in,
   input  wire logic collide_in,
   output logic      scl_oe_n_out,
   output logic      sda_oe_n_out
);
   int         cnt = 9;
   logic [7:0] sh = 8'h00;
   initial begin
      scl_oe_n_out = 1'b1;
      sda_oe_n_out = 1'b1;
   end
   always @(negedge sda_in) if (scl_in) cnt = 0;
   always @(posedge scl_in) begin
      sh = {sh[6:0], sda_in};
      cnt = cnt + 1;
   end
   // Ack own address, or contest address bits
   always @(negedge scl_in) begin
      if (cnt == 8 && sh[7:1] == ADDR || cnt < 8 && collide_in) begin
         sda_oe_n_out = 1'b0;
      end else if (scl_oe_n_out) begin
         sda_oe_n_out = 1'b1;
      end
   end
   // Foreign start, then stop or plain release
   task automatic bus_start();
      #1 sda_oe_n_out = 1'b0;
      #125 scl_oe_n_out = 1'b0;
   endtask
   task automatic bus_end(input logic stop);
      #1 sda_oe_n_out = !stop;
      #125 scl_oe_n_out = 1'b1;
      #125 sda_oe_n_out = 1'b1;
   endtask
endmodule
`default_nettype wire

/* test/i2c_host_bus_test.sv */
// Self-checking bench for the I2C host block
`timescale 1ns/1ps
`default_nettype none
module i2c_host_bus_test;
   import i2c_host_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic        collide = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  be = 4'hf;
   logic [31:0] rdo, rdata;
   logic        waitreq, h_scl_n, h_sda_n, p_scl_n, p_sda_n, o_scl, o_sda;
   wire logic   scl = h_scl_n & p_scl_n;
   wire logic   sda = h_sda_n & p_sda_n;
   int          n_mismatch = 0;
   int          n_tests = 0;
   i2c_host_bus #(.INACT_CYC1(40), .INACT_CYC2(60), .INACT_CYC3(80)) dut_u (
      .sys_clk_in(clk), .rst_in(rst), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_byteenable_in(be), .avs_readdata_out(rdo),
      .avs_waitrequest_out(waitreq), .scl_in(scl), .sda_in(sda),
      .scl_out(o_scl), .scl_oe_n_out(h_scl_n), .sda_out(o_sda),
      .sda_oe_n_out(h_sda_n));
   i2c_bus_partner part_u (.scl_in(scl), .sda_in(sda), .collide_in(collide),
      .scl_oe_n_out(p_scl_n), .sda_oe_n_out(p_sda_n));
   initial begin
      forever #2 clk = ~clk;
   end
   // ==========
   // Shared tasks
   task automatic summarize();
      $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic bus(input logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      do @(posedge clk); while (waitreq !== 1'b0);
      rdata = rdo;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic poll(input logic [31:0] m, v);
      bus(1'b0, OFS_STATUS, 32'h0);
      for (int i = 0; i < 300 && (rdata & m) !== v; i++)
         bus(1'b0, OFS_STATUS, 32'h0);
   endtask
   task automatic state_is(input logic [1:0] e);
      poll(32'h3, {30'h0, e});
      check("bus state", rdata & 32'h3, {30'h0, e});
   endtask
   task automatic phase_len(input logic lv, output int n);
      n = 0;
      while (h_scl_n !== lv) @(posedge clk);
      while (h_scl_n === lv) begin
         @(posedge clk);
         n++;
      end
   endtask
   // ==========
   // Scenarios
   task automatic t_state();
      be <= 4'h3;
      bus(1'b1, OFS_BAUD, 32'hffff_0402);
      be <= 4'hf;
      bus(1'b1, OFS_CTRL, 32'h1);
      bus(1'b0, OFS_BAUD, 32'h0);
      check("baud lanes", rdata, 32'h0000_0402);
      state_is(BS_UNKNOWN);
      bus(1'b0, 8'h20, 32'h0);
      check("unmapped", rdata, 32'h0);
      bus(1'b1, OFS_STATUS, 32'h1);
      state_is(BS_IDLE);
      part_u.bus_start();
      state_is(BS_BUSY);
      part_u.bus_end(1'b1);
      state_is(BS_IDLE);
   endtask
   task automatic t_addr();
      int n;
      bus(1'b1, OFS_ADDR, 32'h54);
      phase_len(1'b0, n);
      check("scl low", n, 32'd9);
      state_is(BS_OWNER);
      poll(32'h20, 32'h20);
      check("ack flags", rdata & 32'h3c, 32'h20);
      check("scl held", {31'h0, h_scl_n}, 32'h0);
      check("drive", {30'h0, o_scl, o_sda}, 32'h0);
      bus(1'b1, OFS_ADDR, 32'h22);
      poll(32'h20, 32'h20);
      check("nack flags", rdata & 32'h3f, 32'h32);
      bus(1'b1, OFS_ADDR, 32'h54);
      poll(32'h20, 32'h20);
      check("new flags", rdata & 32'h3c, 32'h20);
      bus(1'b1, OFS_CMD, {30'h0, CMD_STOP});
      state_is(BS_IDLE);
      check("lines", {30'h0, h_scl_n, h_sda_n}, 32'h3);
   endtask
   task automatic t_arb();
      collide <= 1'b1;
      bus(1'b1, OFS_ADDR, 32'h54);
      poll(32'h20, 32'h20);
      check("arb flags", rdata & 32'h3f, 32'h27);
      check("lines", {30'h0, h_scl_n, h_sda_n}, 32'h3);
      collide <= 1'b0;
      part_u.bus_end(1'b1);
      state_is(BS_IDLE);
   endtask
   task automatic t_timeout();
      bus(1'b1, OFS_CTRL, 32'h2);
      bus(1'b1, OFS_BAUD, 32'h0000_0402);
      bus(1'b1, OFS_CTRL, 32'h21);
      state_is(BS_IDLE);
      part_u.bus_start();
      state_is(BS_BUSY);
      part_u.bus_end(1'b0);
      state_is(BS_IDLE);
   endtask
   task automatic t_fast();
      int n;
      bus(1'b1, OFS_CTRL, 32'h0);
      bus(1'b1, OFS_BAUD, 32'h0002_0402);
      bus(1'b1, OFS_CTRL, 32'h1d);
      bus(1'b1, OFS_STATUS, 32'h1);
      bus(1'b1, OFS_ADDR, 32'h54);
      phase_len(1'b0, n);
      check("smart low", n, 32'd7);
      phase_len(1'b1, n);
      check("fast high", n, 32'd3);
      poll(32'h20, 32'h20);
      check("fast ack", rdata & 32'h3f, 32'h22);
      bus(1'b1, OFS_STATUS, 32'h20);
      bus(1'b1, OFS_DATA, 32'h5a);
      poll(32'h20, 32'h20);
      check("data nack", rdata & 32'h3f, 32'h32);
      bus(1'b1, OFS_CMD, {30'h0, CMD_STOP});
      state_is(BS_IDLE);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_state();
      t_addr();
      t_arb();
      t_timeout();
      t_fast();
      summarize();
   end
   initial begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      summarize();
   end
endmodule
`default_nettype wire
